// file: dv/tb.sv
// Testbench: self-checking scenarios for the watchdog power block
`timescale 1ns/10ps
`default_nettype none
module tb
  import wdt_pkg::*;
;
  logic               clk, rst_n, low_speed_rc_osc_clk, halt_instr, clear_watchdog_instr_instr;
  logic               irq_req, irq_enabled, stack_full, wr_en, rd_en;
  logic               cpu_halted, hi_clk_on, sub_clk_on, resume_next, irq_take;
  logic               pc_sp_reset, device_reset;
  logic [PORTA_W-1:0] porta_pins;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata, rdata;
  logic [2:0]         lcnt = 3'h0;
  logic [3:0]         ev;
  int                 err_total, n_checks, n;

  always #2 clk = ~clk;
  // Slow clock, eight system cycles a period
  always @(posedge clk) begin
    lcnt     <= lcnt + 3'h1;
    low_speed_rc_osc_clk <= lcnt[2];
  end
  assign ev = {device_reset, pc_sp_reset, irq_take, resume_next};

  wdt_power_ctrl #(.KEY_DLY(3)) i_wdt_power_ctrl (
    .clk, .rst_n, .low_speed_rc_osc_clk, .porta_pins, .halt_instr, .clear_watchdog_instr_instr, .irq_req,
    .irq_enabled, .stack_full, .addr, .wdata, .wr_en, .rd_en, .rdata, .cpu_halted,
    .hi_clk_on, .sub_clk_on, .resume_next, .irq_take, .pc_sp_reset, .device_reset);

  // ****
  // Drivers and checks
  // ****
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'h1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    chk(rdata, e);
  endtask
  // Halt pulse when h is set, else clear-watchdog pulse
  task automatic pls(input logic h);
    @(posedge clk);
    {halt_instr, clear_watchdog_instr_instr} <= h ? 2'h2 : 2'h1;
    @(posedge clk);
    {halt_instr, clear_watchdog_instr_instr} <= 2'h0;
    #1;
  endtask
  // Wait for event k; n holds the cycles taken
  task automatic wt(input int k, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if (ev[k]) break;
    end
    if (n == lim) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
      summarize();
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    rd(ADDR_WD_CTRL, WD_CTRL_RESET);
    rd(ADDR_KEY_RST, KEY_RST_RESET);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h00);
    rd(4'hF, 8'h00);
    chk1(hi_clk_on & sub_clk_on, 1'h1);
    $display("reset test done");
  endtask
  task automatic t_idle();
    wr(ADDR_WAKE_EN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SYS_CLK, 8'(k));
      pls(1'h1);
      chk1(cpu_halted, 1'h1);
      chk1(hi_clk_on, k[1]);
      chk1(sub_clk_on, k[0]);
      rd(ADDR_STATUS, 8'h05);
      porta_pins <= 5'h1D;
      repeat (20) @(posedge clk);
      chk1(cpu_halted, 1'h1);
      porta_pins <= 5'h1C;
      wt(0, 20);
      chk1(irq_take, 1'h0);
      porta_pins <= 5'h1F;
      pls(1'h0);
      rd(ADDR_STATUS, 8'h00);
    end
    $display("idle test done");
  endtask
  task automatic t_irq();
    for (int k = 0; k < 3; k++) begin
      irq_enabled <= k != 1;
      stack_full  <= k == 2;
      pls(1'h1);
      irq_req <= 1'h1;
      wt(k == 0 ? 1 : 0, 20);
      chk1(k == 0 ? resume_next : irq_take, 1'h0);
      irq_req <= 1'h0;
      repeat (2) @(posedge clk);
    end
    irq_enabled <= 1'h0;
    irq_req     <= 1'h1;
    pls(1'h1);
    repeat (20) @(posedge clk);
    chk1(cpu_halted, 1'h1);
    irq_req <= 1'h0;
    repeat (5) @(posedge clk);
    irq_req <= 1'h1;
    wt(0, 20);
    irq_req <= 1'h0;
    pls(1'h0);
    $display("interrupt test done");
  endtask
  task automatic t_key();
    wr(ADDR_WD_CTRL, {KEY_ENABLE_B, 3'h3});
    repeat (20) @(posedge clk);
    rd(ADDR_WD_CTRL, {KEY_ENABLE_B, 3'h3});
    rd(ADDR_KEY_RST, 8'h00);
    wr(ADDR_WD_CTRL, 8'h03);
    wt(3, 20);
    chk1(n inside {[1:6]}, 1'h1);
    rd(ADDR_KEY_RST, 8'h01);
    rd(ADDR_WD_CTRL, WD_CTRL_RESET);
    wr(ADDR_KEY_RST, 8'h01);
    rd(ADDR_KEY_RST, 8'h01);
    wr(ADDR_KEY_RST, 8'h00);
    rd(ADDR_KEY_RST, 8'h00);
    $display("key test done");
  endtask
  task automatic t_ovf();
    wr(ADDR_WD_CTRL, {KEY_ENABLE_A, 3'h0});
    pls(1'h1);
    wt(2, 2200);
    chk1(n inside {[2000:2100]}, 1'h1);
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS, 8'h03);
    wt(3, 2200);
    chk1(n inside {[1900:2100]}, 1'h1);
    rd(ADDR_STATUS, 8'h03);
    rd(ADDR_WD_CTRL, WD_CTRL_RESET);
    wr(ADDR_WD_CTRL, {KEY_ENABLE_A, 3'h0});
    pls(1'h0);
    repeat (4) begin
      repeat (1500) @(posedge clk);
      pls(1'h0);
    end
    rd(ADDR_WD_CTRL, {KEY_ENABLE_A, 3'h0});
    wr(ADDR_WD_CTRL, {KEY_ENABLE_A, 3'h1});
    pls(1'h0);
    wt(3, 8400);
    chk1(n inside {[8000:8300]}, 1'h1);
    rd(ADDR_STATUS, 8'h02);
    $display("overflow test done");
  endtask

  initial begin
    {clk, rst_n, halt_instr, clear_watchdog_instr_instr, irq_req} = 5'h00;
    {irq_enabled, stack_full, wr_en, rd_en} = 4'h0;
    {addr, wdata} = 12'h000;
    porta_pins = 5'h1F;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_idle();
    t_irq();
    t_key();
    t_ovf();
    summarize();
  end
endmodule
`default_nettype wire

// file: dv/wdt_power_ctrl_properties.sv
// Checker: port properties of the watchdog power block
`timescale 1ns/10ps
`default_nettype none
module wdt_props
  import wdt_pkg::*;
#(
  parameter int KEY_DLY = KEY_DELAY_CYC
) (
  input wire logic              clk,          // Clock
  input wire logic              rst_n,        // Reset
  input wire logic              halt_instr,   // Halt
  input wire logic              irq_enabled,  // Irq on
  input wire logic              stack_full,   // Stack full
  input wire logic              rd_en,        // Read
  input wire logic [DATA_W-1:0] rdata,        // Data
  input wire logic              cpu_halted,   // Halted
  input wire logic              hi_clk_on,    // Fast clk
  input wire logic              sub_clk_on,   // Sub clk
  input wire logic              resume_next,  // Resume
  input wire logic              irq_take,     // Irq resp
  input wire logic              pc_sp_reset,  // PC/SP rst
  input wire logic              device_reset  // Dev rst
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  halt_enter_a: assert property (
    halt_instr && !cpu_halted |=> cpu_halted) else $error("halt not entered");
  halt_cause_a: assert property (
    $rose(cpu_halted) |-> $past(halt_instr)) else $error("halt without cause");
  wake_release_a: assert property (
    (resume_next || irq_take) |-> cpu_halted ##1 !cpu_halted) else $error("wake timing");
  wake_single_a: assert property (
    resume_next |-> !irq_take ##1 !resume_next) else $error("wake pulse wrong");
  irq_cause_a: assert property (
    irq_take |-> $past(irq_enabled) && !$past(stack_full)) else $error("bad irq response");
  pcsp_halt_a: assert property (
    pc_sp_reset |-> $past(cpu_halted)) else $error("pc reset outside halt");
  dev_run_a: assert property (
    device_reset |-> !$past(cpu_halted)) else $error("device reset in halt");
  run_clocks_a: assert property (
    !cpu_halted |-> hi_clk_on && sub_clk_on) else $error("clock off while running");
  halt_clocks_a: assert property (
    cpu_halted && $past(cpu_halted) |-> $stable({hi_clk_on, sub_clk_on}))
    else $error("clock changed in halt");
  rdata_idle_a: assert property (
    !$past(rd_en) |-> rdata == 8'h00) else $error("read data not idle");
endmodule
bind wdt_power_ctrl wdt_props #(.KEY_DLY(KEY_DLY)) i_wdt_props (.clk, .rst_n, .halt_instr,
  .irq_enabled, .stack_full, .rd_en, .rdata, .cpu_halted, .hi_clk_on, .sub_clk_on,
  .resume_next, .irq_take, .pc_sp_reset, .device_reset);
`default_nettype wire

// file: hdl/wake_detect.sv
// Module: Port A falling-edge wake detector with per-pin enables
`timescale 1ns/10ps
`default_nettype none
module wake_detect
  import wdt_pkg::*;
#(
  parameter int W = PORTA_W
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst_n,     // Async reset, active low
  input  wire logic [W-1:0] pins,      // Port A pins, asynchronous
  input  wire logic [W-1:0] enable,    // Per-pin wake enables
  output var  logic         fall_wake  // Enabled falling edge seen
);
  logic [W-1:0] s1_r, s2_r, s3_r;
  logic [W-1:0] s1_nxt, s2_nxt, s3_nxt;

  always_comb begin
    s1_nxt = pins;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    fall_wake = |(s3_r & ~s2_r & enable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end
endmodule
`default_nettype wire

// file: hdl/wdt_counter.sv
// Module: 18-bit watchdog counter ticked by the synchronised low-speed clock
`timescale 1ns/10ps
`default_nettype none
module wdt_counter
  import wdt_pkg::*;
(
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Async reset, active low
  input  wire logic low_speed_rc_osc_in,  // Low-speed RC clock, asynchronous
  wdt_tick_if.cnt   tick      // Counter controls
);
  logic [2:0]          low_speed_rc_osc_sync_r;
  logic [2:0]          low_speed_rc_osc_sync_nxt;
  logic [WD_CNT_W-1:0] cnt_r;
  logic [WD_CNT_W-1:0] cnt_nxt;
  logic                ovf_r;
  logic                ovf_nxt;
  logic                low_speed_rc_osc_rise;
  logic [4:0]          tap;
  logic [WD_CNT_W-1:0] tap_mask;

  always_comb begin
    low_speed_rc_osc_sync_nxt = {low_speed_rc_osc_sync_r[1:0], low_speed_rc_osc_in};
    low_speed_rc_osc_rise     = low_speed_rc_osc_sync_r[1] & ~low_speed_rc_osc_sync_r[2];
    tap           = tap_of(tick.period_sel);
    // Ones from bit 0 up to the tap, so no variable part-select is needed
    tap_mask      = ~({WD_CNT_W{1'b1}} << (tap + 5'h01));
    cnt_nxt       = cnt_r;
    ovf_nxt       = 1'b0;
    if (tick.clear) begin
      cnt_nxt = '0;
    end else if (low_speed_rc_osc_rise) begin
      cnt_nxt = cnt_r + 1'b1;
      ovf_nxt = ((cnt_r & tap_mask) == tap_mask) ? 1'b1 : 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_speed_rc_osc_sync_r <= '0;
      cnt_r       <= '0;
      ovf_r       <= 1'b0;
    end else begin
      low_speed_rc_osc_sync_r <= low_speed_rc_osc_sync_nxt;
      cnt_r       <= cnt_nxt;
      ovf_r       <= ovf_nxt;
    end
  end

  assign tick.overflow = ovf_r;
endmodule
`default_nettype wire

// file: hdl/wdt_pkg.sv
// Package: register map, field layout, reset values and timing for the watchdog block
package wdt_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam logic [3:0]  ADDR_WD_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_KEY_RST    = 4'h1;
  localparam logic [3:0]  ADDR_SYS_CLK    = 4'h2;
  localparam logic [3:0]  ADDR_WAKE_EN    = 4'h3;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [7:0]  WD_CTRL_RESET   = 8'h53;
  localparam logic [7:0]  KEY_RST_RESET   = 8'h00;
  localparam logic [4:0]  KEY_ENABLE_A    = 5'h0A;
  localparam logic [4:0]  KEY_ENABLE_B    = 5'h15;
  localparam int          KEY_MSB         = 7;
  localparam int          KEY_LSB         = 3;
  localparam int          SEL_MSB         = 2;
  localparam int          SYS_HI_BIT      = 1;
  localparam int          SYS_LO_BIT      = 0;
  localparam int          ST_PDF_BIT      = 0;
  localparam int          ST_TO_BIT       = 1;
  localparam int          ST_HALT_BIT     = 2;
  localparam int          WD_CNT_W        = 18;
  localparam int          PORTA_W         = 5;
  localparam int          KEY_DELAY_NS    = 1000;
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          KEY_DELAY_CYC   = (KEY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          KEY_DLY_W       = 9;

  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_HALT  = 2'b01,
    PM_WAKE  = 2'b11
  } pm_state_t;

  typedef enum logic [1:0] {
    IM_SLEEP = 2'b00,
    IM_IDLE0 = 2'b01,
    IM_IDLE_BOTH_OSC = 2'b11,
    IM_IDLE_FAST_OSC_ONLY = 2'b10
  } idle_mode_t;

  // Tap index for each period-select code
  function automatic logic [4:0] tap_of(input logic [2:0] sel);
    case (sel)
      3'h0:    tap_of = 5'h07;
      3'h1:    tap_of = 5'h09;
      3'h2:    tap_of = 5'h0B;
      3'h3:    tap_of = 5'h0D;
      3'h4:    tap_of = 5'h0E;
      3'h5:    tap_of = 5'h0F;
      3'h6:    tap_of = 5'h10;
      default: tap_of = 5'h11;
    endcase
  endfunction

  function automatic logic key_ok(input logic [4:0] key);
    key_ok = (key == KEY_ENABLE_A) || (key == KEY_ENABLE_B);
  endfunction
endpackage

// file: hdl/wdt_power_ctrl.sv
// Module: watchdog, halt/idle entry and wake-up control (top)
//
// Overview of operation
// - Halt with both keep bits set enters idle with both clocks running.
// - Halt with fast keep only enters idle; sub clock stops.
// - Idle entry leaves memory, registers and ports untouched.
// - Halt sets power-down flag, clears time-out flag and counter.
// - Power-up or clear-watchdog instruction clears power-down flag.
// - Wake from halt on Port A edge, interrupt or watchdog overflow.
// - A Port A pin wakes only when its wake enable is set.
// - After Port A wake, resume at instruction after halt.
// - Disabled or stack-full interrupt resumes after halt, stays pending.
// - Enabled interrupt with free stack takes normal interrupt response.
// - Interrupt already pending before halt does not wake.
// - Overflow in halt sets time-out flag, resets only PC and SP.
// - Overflow in normal run fully resets device and sets time-out flag.
// - Counter runs from low-speed RC clock, divide 2^8 to 2^18.
// - Period codes 0 to 6 select 2^8..2^17 periods.
// - Only two enable keys valid; others reset after delay, set flag.
// - Enable key powers up to the first valid key.
// - Key-reset flag set by hardware only; software clears by zero.
// - Counter cleared by key reset, clear instruction, or halt.
// - Period code 7 selects 2^18 periods.
// - Overflow in run sets time-out flag, keeps power-down flag.
`timescale 1ns/10ps
`default_nettype none
module wdt_power_ctrl
  import wdt_pkg::*;
#(
  parameter int KEY_DLY = KEY_DELAY_CYC
) (
  input  wire logic               clk,          // System clock, 250 MHz
  input  wire logic               rst_n,        // Power-on reset, active low
  input  wire logic               low_speed_rc_osc_clk,     // Low-speed RC clock, async
  input  wire logic [PORTA_W-1:0] porta_pins,   // Port A pin levels, async
  input  wire logic               halt_instr,   // Halt executed, pulse
  input  wire logic               clear_watchdog_instr_instr,// Clear-watchdog executed, pulse
  input  wire logic               irq_req,      // Interrupt request level
  input  wire logic               irq_enabled,  // Requesting interrupt enabled
  input  wire logic               stack_full,   // Stack has no free level
  input  wire logic [ADDR_W-1:0]  addr,         // Register address
  input  wire logic [DATA_W-1:0]  wdata,        // Write data
  input  wire logic               wr_en,        // Write strobe
  input  wire logic               rd_en,        // Read strobe
  output var  logic [DATA_W-1:0]  rdata,        // Read data, cycle after strobe
  output var  logic               cpu_halted,   // Program execution stopped
  output var  logic               hi_clk_on,    // High-speed clock enable
  output var  logic               sub_clk_on,   // Sub clock enable
  output var  logic               resume_next,  // Wake: continue after halt, pulse
  output var  logic               irq_take,     // Wake: interrupt response, pulse
  output var  logic               pc_sp_reset,  // Reset PC and SP only, pulse
  output var  logic               device_reset  // Full device reset, pulse
);
  // ****************************************
  // Registers
  // ****************************************
  logic [DATA_W-1:0]  wd_ctrl_r, wd_ctrl_nxt;
  logic               key_flag_r, key_flag_nxt;
  logic [1:0]         sys_clk_r, sys_clk_nxt;
  logic [PORTA_W-1:0] wake_en_r, wake_en_nxt;
  logic               pdf_r, pdf_nxt;
  logic               to_r, to_nxt;
  logic [DATA_W-1:0]  rdata_nxt;
  pm_state_t          pm_r, pm_nxt;
  idle_mode_t         mode_r, mode_nxt;
  logic               irq_masked_r, irq_masked_nxt;
  logic [KEY_DLY_W-1:0] key_cnt_r, key_cnt_nxt;
  logic               key_pend_r, key_pend_nxt;
  logic               hi_on_nxt, sub_on_nxt, halted_nxt;
  logic               resume_nxt, take_nxt, pcsp_nxt, devrst_nxt;
  logic               fall_wake;
  logic               wake_irq;
  logic               key_fire;

  wdt_tick_if tick ();

  wdt_counter u_counter (
    .clk     (clk),
    .rst_n   (rst_n),
    .low_speed_rc_osc_in (low_speed_rc_osc_clk),
    .tick    (tick)
  );

  wake_detect #(
    .W (PORTA_W)
  ) u_wake (
    .clk       (clk),
    .rst_n     (rst_n),
    .pins      (porta_pins),
    .enable    (wake_en_r),
    .fall_wake (fall_wake)
  );

  // ****************************************
  // Key check and software-reset delay
  // ****************************************
  always_comb begin
    key_cnt_nxt  = key_cnt_r;
    key_pend_nxt = key_pend_r;
    key_fire     = 1'b0;
    if (!key_ok(wd_ctrl_r[KEY_MSB:KEY_LSB])) begin
      if (!key_pend_r) begin
        key_pend_nxt = 1'b1;
        key_cnt_nxt  = KEY_DLY_W'(KEY_DLY - 1);
      end else if (key_cnt_r == '0) begin
        key_fire     = 1'b1;
        key_pend_nxt = 1'b0;
      end else begin
        key_cnt_nxt = key_cnt_r - 1'b1;
      end
    end else begin
      key_pend_nxt = 1'b0;
    end
  end

  // ****************************************
  // Register file and flags
  // ****************************************
  always_comb begin
    wd_ctrl_nxt  = wd_ctrl_r;
    key_flag_nxt = key_flag_r;
    sys_clk_nxt  = sys_clk_r;
    wake_en_nxt  = wake_en_r;
    pdf_nxt      = pdf_r;
    to_nxt       = to_r;
    rdata_nxt    = '0;
    if (wr_en) begin
      case (addr)
        ADDR_WD_CTRL: wd_ctrl_nxt = wdata;
        ADDR_KEY_RST: key_flag_nxt = key_flag_r & wdata[0];
        ADDR_SYS_CLK: sys_clk_nxt = wdata[1:0];
        ADDR_WAKE_EN: wake_en_nxt = wdata[PORTA_W-1:0];
        default:      wd_ctrl_nxt = wd_ctrl_r;
      endcase
    end
    if (clear_watchdog_instr_instr) begin
      pdf_nxt = 1'b0;
    end
    if (halt_instr && pm_r == PM_RUN) begin
      pdf_nxt = 1'b1;
      to_nxt  = 1'b0;
    end
    if (tick.overflow) begin
      to_nxt = 1'b1;
    end
    if (key_fire) begin
      // key reset reloads control, flags kept
      wd_ctrl_nxt  = WD_CTRL_RESET;
      sys_clk_nxt  = '0;
      wake_en_nxt  = '0;
      // hardware sets flag, wins over clear
      key_flag_nxt = 1'b1;
    end else if (tick.overflow && pm_r == PM_RUN) begin
      wd_ctrl_nxt = WD_CTRL_RESET;
      sys_clk_nxt = '0;
      wake_en_nxt = '0;
    end
    if (rd_en) begin
      case (addr)
        ADDR_WD_CTRL: rdata_nxt = wd_ctrl_r;
        ADDR_KEY_RST: rdata_nxt = {7'h00, key_flag_r};
        ADDR_SYS_CLK: rdata_nxt = {6'h00, sys_clk_r};
        ADDR_WAKE_EN: rdata_nxt = {{(DATA_W-PORTA_W){1'b0}}, wake_en_r};
        ADDR_STATUS:  rdata_nxt = {5'h00, cpu_halted, to_r, pdf_r};
        default:      rdata_nxt = '0;
      endcase
    end
  end

  // ****************************************
  // Halt, idle and wake sequencing
  // ****************************************
  assign wake_irq = irq_req & ~irq_masked_r;

  always_comb begin
    pm_nxt         = pm_r;
    mode_nxt       = mode_r;
    irq_masked_nxt = irq_masked_r;
    halted_nxt     = cpu_halted;
    hi_on_nxt      = hi_clk_on;
    sub_on_nxt     = sub_clk_on;
    resume_nxt     = 1'b0;
    take_nxt       = 1'b0;
    pcsp_nxt       = 1'b0;
    devrst_nxt     = key_fire | (tick.overflow & (pm_r == PM_RUN));
    case (pm_r)
      PM_RUN: begin
        if (halt_instr) begin
          pm_nxt     = PM_HALT;
          halted_nxt = 1'b1;
          irq_masked_nxt = irq_req;
          mode_nxt   = idle_mode_t'({sys_clk_r[SYS_HI_BIT], sys_clk_r[SYS_LO_BIT]});
          hi_on_nxt  = sys_clk_r[SYS_HI_BIT];
          sub_on_nxt = sys_clk_r[SYS_LO_BIT];
        end
      end
      PM_HALT: begin
        if (!irq_req) begin
          irq_masked_nxt = 1'b0;
        end
        if (tick.overflow) begin
          pcsp_nxt = 1'b1;
          pm_nxt   = PM_WAKE;
        end else if (wake_irq) begin
          take_nxt   = irq_enabled & ~stack_full;
          resume_nxt = ~(irq_enabled & ~stack_full);
          pm_nxt     = PM_WAKE;
        end else if (fall_wake) begin
          resume_nxt = 1'b1;
          pm_nxt     = PM_WAKE;
        end
        if (key_fire) begin
          pm_nxt = PM_WAKE;
        end
      end
      PM_WAKE: begin
        pm_nxt         = PM_RUN;
        halted_nxt     = 1'b0;
        hi_on_nxt      = 1'b1;
        sub_on_nxt     = 1'b1;
        irq_masked_nxt = 1'b0;
      end
      default: begin
        pm_nxt = PM_RUN;
      end
    endcase
  end

  assign tick.clear      = key_fire | clear_watchdog_instr_instr | (halt_instr & (pm_r == PM_RUN));
  assign tick.period_sel = wd_ctrl_r[SEL_MSB:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_ctrl_r    <= WD_CTRL_RESET;
      key_flag_r   <= KEY_RST_RESET[0];
      sys_clk_r    <= '0;
      wake_en_r    <= '0;
      pdf_r        <= 1'b0;
      to_r         <= 1'b0;
      rdata        <= '0;
      key_cnt_r    <= '0;
      key_pend_r   <= 1'b0;
      pm_r         <= PM_RUN;
      mode_r       <= IM_SLEEP;
      irq_masked_r <= 1'b0;
      cpu_halted   <= 1'b0;
      hi_clk_on    <= 1'b1;
      sub_clk_on   <= 1'b1;
      resume_next  <= 1'b0;
      irq_take     <= 1'b0;
      pc_sp_reset  <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      wd_ctrl_r    <= wd_ctrl_nxt;
      key_flag_r   <= key_flag_nxt;
      sys_clk_r    <= sys_clk_nxt;
      wake_en_r    <= wake_en_nxt;
      pdf_r        <= pdf_nxt;
      to_r         <= to_nxt;
      rdata        <= rdata_nxt;
      key_cnt_r    <= key_cnt_nxt;
      key_pend_r   <= key_pend_nxt;
      pm_r         <= pm_nxt;
      mode_r       <= mode_nxt;
      irq_masked_r <= irq_masked_nxt;
      cpu_halted   <= halted_nxt;
      hi_clk_on    <= hi_on_nxt;
      sub_clk_on   <= sub_on_nxt;
      resume_next  <= resume_nxt;
      irq_take     <= take_nxt;
      pc_sp_reset  <= pcsp_nxt;
      device_reset <= devrst_nxt;
    end
  end
endmodule
`default_nettype wire

// file: hdl/wdt_tick_if.sv
// Interface: watchdog counter controls and overflow event
`timescale 1ns/10ps
`default_nettype none
interface wdt_tick_if;
  logic       clear;
  logic [2:0] period_sel;
  logic       overflow;
  modport ctrl (output clear, output period_sel, input overflow);
  modport cnt  (input clear, input period_sel, output overflow);
endinterface
`default_nettype wire
